//--- shared/fwp_protect_defs.vh
// constants for the serial flash write-protection and status block
// How it works
// - while supply reset is active all logic is held and every instruction ignored
// - reset pin low or the reset command pair restarts power-on initialisation
// - one lock bit per middle 64KB block, one per 4KB top/bottom sector
// - erase or program to a region whose lock bit is 1 is ignored
// - every individual lock bit comes up as 1 after reset
// - scheme select 0 uses range protection, 1 uses individual lock bits
// - in power-down only the release instruction is obeyed
// - busy flag bit 0 is 1 during operations; only status reads and suspend accepted
// - write-latch flag bit 1 becomes 1 after the write-latch-set instruction
// - write latch cleared at reset and after disable, program, erase, status write
// - range bits writable by status write, reset to 0 meaning nothing protected
// - range-from-bottom bit 0 protects from top, 1 from bottom; resets to 0
// - status lock mode bits sit at status bits 8 and 7
// - lock mode 00 ignores the protect pin; status writes need the write latch or the 50h enable
// - lock mode 01 with protect pin low blocks status writes
// - lock mode 10 refuses status writes until power cycle, which restores 00
// - lock mode 11 refuses all status writes until power cycle, which restores 00
// - status write permission from lock mode bits, write latch or 50h enable, and protect pin
// - every status bit resets to 0
// - opcodes 05h, 01h, 06h, 04h, 50h, 35h, 31h as listed
// - invert bit 1 inverts the range protection; resets to 0
`ifndef FWP_PROTECT_DEFS_VH
`define FWP_PROTECT_DEFS_VH
`define FWP_OP_RD_ST1     8'h05
`define FWP_OP_WR_ST      8'h01
`define FWP_OP_WL_SET     8'h06
`define FWP_OP_WL_CLR     8'h04
`define FWP_OP_VOL_EN     8'h50
`define FWP_OP_RD_ST2     8'h35
`define FWP_OP_WR_ST2     8'h31
`define FWP_OP_UNLOCK     8'h39
`define FWP_OP_LOCK       8'h36
`define FWP_OP_PROG       8'h02
`define FWP_OP_QPROG      8'h32
`define FWP_OP_SEC_ERASE  8'h20
`define FWP_OP_BLK_ERASE  8'hD8
`define FWP_OP_CHIP_ERASE 8'hC7
`define FWP_OP_SUSPEND    8'h75
`define FWP_OP_PDOWN      8'hB9
`define FWP_OP_PD_REL     8'hAB
`define FWP_OP_RST_EN     8'h66
`define FWP_OP_RST        8'h99
`define FWP_SR2_WPS_BIT   4
`define FWP_SR2_CMP_BIT   6
`define FWP_SR_RESET      8'h00
`define FWP_LOCK_BLOCKS   254
`define FWP_LOCK_SECTORS  32
`define FWP_CLK_NS        100
`define FWP_T_WRST_US     5000
`define FWP_T_PROG_US     700
`define FWP_T_ERASE_US    45000
`define FWP_KIND_PROG     2'h0
`define FWP_KIND_SECTOR   2'h1
`define FWP_KIND_BLOCK    2'h2
`define FWP_KIND_CHIP     2'h3
`endif

//--- hdl/fwp_protect_status.v
// status registers, write latch and array write protection of the serial flash
`timescale 1ns/1ns
`default_nettype none
`include "fwp_protect_defs.vh"
module fwp_protect_status #(
   parameter BUSY_WRST_CYC  = (`FWP_T_WRST_US * 1000) / `FWP_CLK_NS,
   parameter BUSY_PROG_CYC  = (`FWP_T_PROG_US * 1000) / `FWP_CLK_NS,
   parameter BUSY_ERASE_CYC = (`FWP_T_ERASE_US * 1000) / `FWP_CLK_NS
) (
   // system
   input  wire        clock,
   input  wire        rst_n,
   // serial link pins
   input  wire        sclk,
   input  wire        cs_n,
   input  wire        di,
   input  wire        wp_n,
   input  wire        rst_pin_n,
   output reg         do_out,
   output reg         do_oe,
   // array modification requests
   output reg         mod_start,
   output reg  [1:0]  mod_kind,
   output reg  [23:0] mod_addr,
   output reg         mod_suspend
);
   localparam NLOCK = `FWP_LOCK_BLOCKS + `FWP_LOCK_SECTORS;
   localparam [19:0] WRST_CYC  = BUSY_WRST_CYC[19:0];
   localparam [19:0] PROG_CYC  = BUSY_PROG_CYC[19:0];
   localparam [19:0] ERASE_CYC = BUSY_ERASE_CYC[19:0];
   // idle pin levels, so no false link clock edge follows reset
   localparam [4:0]  PIN_IDLE  = 5'h1A;

   // reset release
   reg         rst_q1;
   reg         rst_s;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_q1 <= 1'b0;
         rst_s  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_s  <= rst_q1;
      end
   end

   // pin synchronisers: a change counts once stages two and three agree
   wire [4:0]  pin_raw = {rst_pin_n, wp_n, di, cs_n, sclk};
   reg  [4:0]  pin_s1;
   reg  [4:0]  pin_s2;
   reg  [4:0]  pin_s3;
   reg  [4:0]  pin_ok;
   reg  [4:0]  pin_old;
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : sync
         always @(posedge clock or negedge rst_s) begin
            if (!rst_s) begin
               pin_s1[g]  <= PIN_IDLE[g];
               pin_s2[g]  <= PIN_IDLE[g];
               pin_s3[g]  <= PIN_IDLE[g];
               pin_ok[g]  <= PIN_IDLE[g];
               pin_old[g] <= PIN_IDLE[g];
            end else begin
               pin_s1[g] <= pin_raw[g];
               pin_s2[g] <= pin_s1[g];
               pin_s3[g] <= pin_s2[g];
               if (pin_s2[g] == pin_s3[g]) begin
                  pin_ok[g] <= pin_s3[g];
               end
               pin_old[g] <= pin_ok[g];
            end
         end
      end
   endgenerate
   wire sclk_rise = pin_ok[0] & ~pin_old[0];
   wire sclk_fall = ~pin_ok[0] & pin_old[0];
   wire cs_fall   = ~pin_ok[1] & pin_old[1];
   wire cs_rise   = pin_ok[1] & ~pin_old[1];
   wire sel       = ~pin_ok[1];
   wire di_v      = pin_ok[2];
   wire wp_high   = pin_ok[3];
   wire pin_reset = ~pin_ok[4];

   // status bits
   reg         busy;
   reg         write_latch_flag;
   reg         vol_en;
   reg  [2:0]  range_bits;
   reg         range_from_bottom;
   reg         granule_select;
   reg         status_lock_mode_lo;
   reg         status_lock_mode_hi;
   reg         quad_en;
   reg         sec_lock;
   reg         protect_scheme_select;
   reg         protect_invert;
   reg  [NLOCK-1:0] lock_bits;
   reg         pdown;
   reg         rst_armed;
   reg  [19:0] busy_cnt;
   wire [7:0]  status_one = {status_lock_mode_lo, granule_select, range_from_bottom,
                             range_bits, write_latch_flag, busy};
   wire [7:0]  status_two = {1'b0, protect_invert, 1'b0, protect_scheme_select,
                             1'b0, sec_lock, quad_en, status_lock_mode_hi};

   // serial frame state
   reg  [7:0]  sh_in;
   reg  [2:0]  bit_cnt;
   reg  [3:0]  byte_cnt;
   reg  [7:0]  cmd;
   reg  [7:0]  dat1;
   reg  [7:0]  dat2;
   reg  [23:0] addr;
   reg  [7:0]  sh_out;
   wire [7:0]  byte_in = {sh_in[6:0], di_v};

   // range protection of one address
   function range_hit;
      input [23:0] a;
      input [2:0]  bp;
      input        bot;
      input        gran;
      input        inv;
      reg   [4:0]  sh;
      reg   [23:0] m;
      reg          hit;
      begin
         sh = 5'h00;
         m = 24'h000000;
         hit = 1'b0;
         if (bp == 3'h7) begin
            hit = 1'b1;
         end else if (bp != 3'h0) begin
            if (gran) begin
               sh = (bp > 3'h4) ? 5'h0F : (5'h0B + {2'h0, bp});
            end else begin
               sh = 5'h11 + {2'h0, bp};
            end
            m = 24'hFFFFFF << sh;
            hit = bot ? ((a & m) == 24'h000000) : ((a & m) == m);
         end
         range_hit = hit ^ inv;
      end
   endfunction

   // index of the lock bit that covers an address
   function [8:0] lock_idx;
      input [23:0] a;
      begin
         if (a[23:16] == 8'h00) begin
            lock_idx = 9'd254 + {5'h00, a[15:12]};
         end else if (a[23:16] == 8'hFF) begin
            lock_idx = 9'd270 + {5'h00, a[15:12]};
         end else begin
            lock_idx = {1'b0, a[23:16]} - 9'd1;
         end
      end
   endfunction

   wire [8:0] cur_idx  = lock_idx(addr);
   wire       lock_hit = lock_bits[cur_idx];
   // scheme select picks which protection counts
   wire       addr_prot = protect_scheme_select ? lock_hit :
                          range_hit(addr, range_bits, range_from_bottom,
                                    granule_select, protect_invert);
   wire       any_prot  = protect_scheme_select ? (|lock_bits) :
                          ((range_bits != 3'h0) | protect_invert);
   // status write permission
   wire       st_mode_ok = ~status_lock_mode_hi &
                           (~status_lock_mode_lo | wp_high);
   wire       st_write_ok = st_mode_ok & (write_latch_flag | vol_en);
   wire       reading = sel & (byte_cnt != 4'h0) & ~pdown &
                        ((cmd == `FWP_OP_RD_ST1) | (cmd == `FWP_OP_RD_ST2));
   // instruction gating: power-down and busy narrow what is obeyed
   wire       pd_ok   = ~pdown | (cmd == `FWP_OP_PD_REL);
   wire       busy_ok = ~busy | (cmd == `FWP_OP_SUSPEND);
   wire       frame_ok = cs_rise & (bit_cnt == 3'h0) & (byte_cnt != 4'h0) &
                         pd_ok & busy_ok;

   always @(posedge clock or negedge rst_s) begin
      if (!rst_s) begin
         // supply reset: whole state to factory values
         busy                  <= 1'b0;
         write_latch_flag                   <= 1'b0;
         vol_en                <= 1'b0;
         range_bits            <= 3'h0;
         range_from_bottom     <= 1'b0;
         granule_select        <= 1'b0;
         status_lock_mode_lo   <= 1'b0;
         status_lock_mode_hi   <= 1'b0;
         quad_en               <= 1'b0;
         sec_lock              <= 1'b0;
         protect_scheme_select <= 1'b0;
         protect_invert        <= 1'b0;
         lock_bits             <= {NLOCK{1'b1}};
         pdown                 <= 1'b0;
         rst_armed             <= 1'b0;
         busy_cnt              <= 20'h00000;
         sh_in                 <= 8'h00;
         bit_cnt               <= 3'h0;
         byte_cnt              <= 4'h0;
         cmd                   <= 8'h00;
         dat1                  <= 8'h00;
         dat2                  <= 8'h00;
         addr                  <= 24'h000000;
         sh_out                <= 8'h00;
         do_out                <= 1'b0;
         do_oe                 <= 1'b0;
         mod_start             <= 1'b0;
         mod_kind              <= 2'h0;
         mod_addr              <= 24'h000000;
         mod_suspend           <= 1'b0;
      end else if (pin_reset) begin
         // reset pin restarts initialisation; non-volatile bits survive
         busy      <= 1'b0;
         busy_cnt  <= 20'h00000;
         write_latch_flag       <= 1'b0;
         vol_en    <= 1'b0;
         lock_bits <= {NLOCK{1'b1}};
         pdown     <= 1'b0;
         rst_armed <= 1'b0;
         bit_cnt   <= 3'h0;
         byte_cnt  <= 4'h0;
         do_oe     <= 1'b0;
         mod_start <= 1'b0;
         mod_suspend <= 1'b0;
      end else begin
         mod_start   <= 1'b0;
         mod_suspend <= 1'b0;
         if (busy) begin
            if (busy_cnt <= 20'h00001) begin
               busy     <= 1'b0;
               busy_cnt <= 20'h00000;
            end else begin
               busy_cnt <= busy_cnt - 20'h00001;
            end
         end
         if (cs_fall) begin
            bit_cnt  <= 3'h0;
            byte_cnt <= 4'h0;
         end else if (sel & sclk_rise) begin
            sh_in   <= byte_in;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               if (byte_cnt != 4'hF) begin
                  byte_cnt <= byte_cnt + 4'h1;
               end
               case (byte_cnt)
                  4'h0: begin
                     cmd <= byte_in;
                  end
                  4'h1: begin
                     dat1        <= byte_in;
                     addr[23:16] <= byte_in;
                  end
                  4'h2: begin
                     dat2       <= byte_in;
                     addr[15:8] <= byte_in;
                  end
                  4'h3: begin
                     addr[7:0] <= byte_in;
                  end
                  default: begin
                  end
               endcase
            end
         end
         // status read data leaves on falling clock, reloaded every byte
         if (reading & sclk_fall) begin
            if (bit_cnt == 3'h0) begin
               do_out <= (cmd == `FWP_OP_RD_ST1) ? status_one[7] : status_two[7];
               sh_out <= (cmd == `FWP_OP_RD_ST1) ? {status_one[6:0], 1'b0} :
                                                   {status_two[6:0], 1'b0};
            end else begin
               do_out <= sh_out[7];
               sh_out <= {sh_out[6:0], 1'b0};
            end
         end
         do_oe <= reading;
         // instructions take effect when the frame closes on a byte boundary
         if (frame_ok) begin
            rst_armed <= (cmd == `FWP_OP_RST_EN);
            case (cmd)
               `FWP_OP_WL_SET: begin
                  write_latch_flag <= 1'b1;
               end
               `FWP_OP_WL_CLR: begin
                  write_latch_flag    <= 1'b0;
                  vol_en <= 1'b0;
               end
               `FWP_OP_VOL_EN: begin
                  vol_en <= 1'b1;
               end
               `FWP_OP_WR_ST: begin
                  if (st_write_ok) begin
                     range_bits          <= dat1[4:2];
                     range_from_bottom   <= dat1[5];
                     granule_select      <= dat1[6];
                     status_lock_mode_lo <= dat1[7];
                     if (byte_cnt >= 4'h3) begin
                        status_lock_mode_hi   <= dat2[0];
                        quad_en               <= dat2[1];
                        sec_lock              <= sec_lock | dat2[2];
                        protect_scheme_select <= dat2[`FWP_SR2_WPS_BIT];
                        protect_invert        <= dat2[`FWP_SR2_CMP_BIT];
                     end
                     write_latch_flag      <= 1'b0;
                     vol_en   <= 1'b0;
                     busy     <= 1'b1;
                     busy_cnt <= WRST_CYC;
                  end
               end
               `FWP_OP_WR_ST2: begin
                  if (st_write_ok) begin
                     status_lock_mode_hi   <= dat1[0];
                     quad_en               <= dat1[1];
                     sec_lock              <= sec_lock | dat1[2];
                     protect_scheme_select <= dat1[`FWP_SR2_WPS_BIT];
                     protect_invert        <= dat1[`FWP_SR2_CMP_BIT];
                     write_latch_flag      <= 1'b0;
                     vol_en   <= 1'b0;
                     busy     <= 1'b1;
                     busy_cnt <= WRST_CYC;
                  end
               end
               `FWP_OP_UNLOCK, `FWP_OP_LOCK: begin
                  if (write_latch_flag & (byte_cnt >= 4'h4)) begin
                     lock_bits[cur_idx] <= (cmd == `FWP_OP_LOCK);
                  end
               end
               `FWP_OP_PROG, `FWP_OP_QPROG, `FWP_OP_SEC_ERASE, `FWP_OP_BLK_ERASE: begin
                  // locked targets (scheme select 1) or range-protected targets (scheme select 0) are dropped untouched
                  if (write_latch_flag & (byte_cnt >= 4'h4) & ~addr_prot) begin
                     mod_start <= 1'b1;
                     mod_addr  <= addr;
                     mod_kind  <= (cmd == `FWP_OP_SEC_ERASE) ? `FWP_KIND_SECTOR :
                                  (cmd == `FWP_OP_BLK_ERASE) ? `FWP_KIND_BLOCK :
                                                               `FWP_KIND_PROG;
                     write_latch_flag       <= 1'b0;
                     busy      <= 1'b1;
                     busy_cnt  <= ((cmd == `FWP_OP_PROG) | (cmd == `FWP_OP_QPROG)) ?
                                  PROG_CYC : ERASE_CYC;
                  end
               end
               `FWP_OP_CHIP_ERASE: begin
                  if (write_latch_flag & ~any_prot) begin
                     mod_start <= 1'b1;
                     mod_addr  <= 24'h000000;
                     mod_kind  <= `FWP_KIND_CHIP;
                     write_latch_flag       <= 1'b0;
                     busy      <= 1'b1;
                     busy_cnt  <= ERASE_CYC;
                  end
               end
               `FWP_OP_SUSPEND: begin
                  mod_suspend <= busy;
               end
               `FWP_OP_PDOWN: begin
                  pdown <= 1'b1;
               end
               `FWP_OP_PD_REL: begin
                  pdown <= 1'b0;
               end
               `FWP_OP_RST: begin
                  // software reset pair restarts initialisation
                  if (rst_armed) begin
                     write_latch_flag       <= 1'b0;
                     vol_en    <= 1'b0;
                     lock_bits <= {NLOCK{1'b1}};
                     pdown     <= 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench/fwp_protect_status_props.sv
// concurrent checks on the ports of the flash protection and status block
`timescale 1ns/1ns
`default_nettype none
module fwp_protect_status_props #(
   parameter int BUSY_WRST_CYC  = 50000,
   parameter int BUSY_PROG_CYC  = 7000,
   parameter int BUSY_ERASE_CYC = 450000
) (
   // system
   input wire logic        clock,
   input wire logic        rst_n,
   // link pins
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        di,
   input wire logic        wp_n,
   input wire logic        rst_pin_n,
   input wire logic        do_out,
   input wire logic        do_oe,
   // array requests
   input wire logic        mod_start,
   input wire logic [1:0]  mod_kind,
   input wire logic [23:0] mod_addr,
   input wire logic        mod_suspend
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   int since;
   // saturates so a long idle spell never wraps
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) since <= 1 << 30;
      else if (mod_start) since <= 1;
      else if (since < (1 << 30)) since <= since + 1;
   end
   sequence s_frame_close;
      $rose(cs_n);
   endsequence
   sequence s_pin_reset;
      (!rst_pin_n) [*8];
   endsequence
   a_oe_ends_frame: assert property (s_frame_close |-> ##[1:8] !do_oe)
      else $error("output enable outlived the frame");
   a_oe_in_frame: assert property ($rose(do_oe) |-> !cs_n)
      else $error("output enable rose outside a frame");
   a_out_on_fall: assert property (do_oe && $changed(do_out) |-> $past(sclk, 6) && !$past(sclk, 5))
      else $error("serial output moved while link clock high");
   a_start_one_cycle: assert property (mod_start |=> !mod_start)
      else $error("array start longer than one cycle");
   a_start_frame_end: assert property (mod_start |-> cs_n && $past(cs_n, 2))
      else $error("array start before the frame closed");
   a_start_not_reading: assert property (mod_start |-> !do_oe)
      else $error("array start during a read");
   a_susp_one_cycle: assert property (mod_suspend |=> !mod_suspend)
      else $error("suspend longer than one cycle");
   a_target_held: assert property ($changed(mod_addr) || $changed(mod_kind) |-> mod_start)
      else $error("array target moved without a start");
   a_busy_spacing: assert property (mod_start |-> since >= BUSY_PROG_CYC)
      else $error("array start accepted while busy");
   a_pin_reset_quiet: assert property (s_pin_reset |-> !do_oe && !mod_start)
      else $error("activity while reset pin held low");
endmodule
bind fwp_protect_status fwp_protect_status_props #(.BUSY_WRST_CYC(BUSY_WRST_CYC),
   .BUSY_PROG_CYC(BUSY_PROG_CYC), .BUSY_ERASE_CYC(BUSY_ERASE_CYC)) u_props (
   .clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .di(di), .wp_n(wp_n),
   .rst_pin_n(rst_pin_n), .do_out(do_out), .do_oe(do_oe), .mod_start(mod_start),
   .mod_kind(mod_kind), .mod_addr(mod_addr), .mod_suspend(mod_suspend));
`default_nettype wire

//--- testbench/fwp_host_model.sv
// serial host model that frames instructions into the protection block
`timescale 1ns/1ns
`default_nettype none
module fwp_host_model (
   // system
   input  wire logic clock,
   // link pins
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic di,
   input  wire logic do_out,
   input  wire logic do_oe
);
   // 800 ns link period at the 100 ns system clock
   localparam int HALF = 4;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      di   = 1'b0;
   end
   task automatic ticks(input int n);
      repeat (n) @(posedge clock);
   endtask
   // mode 0: opcode then nb bytes from the low end of tail; rd is the second byte seen
   task automatic frame(input logic [7:0] op, input logic [31:0] tail, input int nb,
                        output logic [7:0] rd);
      logic [39:0] sh;
      sh = {op, tail << (8 * (4 - nb))};
      rd = 8'h00;
      @(posedge clock);
      cs_n <= 1'b0;
      ticks(HALF);
      for (int i = 0; i < 8 * (nb + 1); i++) begin
         sclk <= 1'b0;
         di   <= sh[39 - i];
         ticks(HALF);
         sclk <= 1'b1;
         ticks(HALF);
         // late sample: output only settles a few clocks after the fall
         if (i >= 8 && i < 16) rd = {rd[6:0], do_out};
      end
      sclk <= 1'b0;
      ticks(HALF);
      cs_n <= 1'b1;
      di   <= ~di;
      ticks(3 * HALF);
   endtask
endmodule
`default_nettype wire

//--- testbench/fwp_protect_status_tb.sv
// self-checking bench for the flash protection and status block
`timescale 1ns/1ns
`default_nettype none
module fwp_protect_status_tb;
   localparam int T_WR = 400;
   localparam int T_PR = 400;
   localparam int T_ER = 600;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        wp_n = 1'b1;
   logic        rst_pin_n = 1'b1;
   wire  logic  sclk, cs_n, di, do_out, do_oe, mod_start, mod_suspend;
   wire  logic [1:0]  mod_kind;
   wire  logic [23:0] mod_addr;
   int          fail_count = 0;
   int          total_checks = 0;
   int          starts = 0;
   int          susps = 0;
   logic [25:0] last_mod = 26'h0;
   logic [7:0]  rd;
   logic [7:0]  ops [3] = '{8'h02, 8'h20, 8'hD8};
   always #50 clock = ~clock;
   always @(posedge clock) begin
      if (mod_start === 1'b1) begin
         starts++;
         last_mod = {mod_kind, mod_addr};
      end
      if (mod_suspend === 1'b1) susps++;
   end
   fwp_protect_status #(.BUSY_WRST_CYC(T_WR), .BUSY_PROG_CYC(T_PR), .BUSY_ERASE_CYC(T_ER)) uut (
      .clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .di(di), .wp_n(wp_n),
      .rst_pin_n(rst_pin_n), .do_out(do_out), .do_oe(do_oe), .mod_start(mod_start),
      .mod_kind(mod_kind), .mod_addr(mod_addr), .mod_suspend(mod_suspend));
   fwp_host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .di(di),
      .do_out(do_out), .do_oe(do_oe));
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_mod(input logic [25:0] got, input logic [25:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [31:0] tail, input int nb);
      host.frame(op, tail, nb, rd);
   endtask
   task automatic rd_st(input logic [7:0] op, input logic [7:0] exp);
      host.frame(op, 32'h0, 1, rd);
      chk_reg(rd, exp);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // whole sequence needs roughly 16k clocks
   initial begin
      #(40000 * 100);
      fail_count++;
      close_out();
   end
   initial begin
      wait_clk(2);
      rst_n <= 1'b1;
      wait_clk(8);
      rd_st(8'h05, 8'h00);
      rd_st(8'h35, 8'h00);
      cmd(8'h06, 32'h0, 0);
      rd_st(8'h05, 8'h02);
      cmd(8'h04, 32'h0, 0);
      rd_st(8'h05, 8'h00);
      $display("test latch done");
      cmd(8'h01, 32'h1C, 1);
      rd_st(8'h05, 8'h00);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h01, 32'h1C, 1);
      rd_st(8'h05, 8'h1D);
      wait_clk(T_WR);
      rd_st(8'h05, 8'h1C);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h02, 32'h000100, 3);
      wait_clk(10);
      chk_reg(starts[7:0], 8'h00);
      rd_st(8'h05, 8'h1E);
      cmd(8'h01, 32'h00, 1);
      wait_clk(T_WR);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h31, 32'h40, 1);
      wait_clk(T_WR);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h02, 32'h000100, 3);
      wait_clk(10);
      chk_reg(starts[7:0], 8'h00);
      cmd(8'h31, 32'h00, 1);
      wait_clk(T_WR);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h02, 32'h000100, 3);
      wait_clk(10);
      chk_reg(starts[7:0], 8'h01);
      chk_mod(last_mod, {2'h0, 24'h000100});
      cmd(8'h06, 32'h0, 0);
      cmd(8'h75, 32'h0, 0);
      chk_reg(susps[7:0], 8'h01);
      wait_clk(T_PR);
      rd_st(8'h05, 8'h00);
      $display("test range scheme done");
      cmd(8'h06, 32'h0, 0);
      cmd(8'h31, 32'h10, 1);
      wait_clk(T_WR);
      rd_st(8'h35, 8'h10);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h02, 32'h123456, 3);
      wait_clk(10);
      chk_reg(starts[7:0], 8'h01);
      cmd(8'h39, 32'h123456, 3);
      for (int k = 0; k < 3; k++) begin
         cmd(8'h06, 32'h0, 0);
         cmd(ops[k], 32'h123456, 3);
         wait_clk(10);
         chk_mod(last_mod, {k[1:0], 24'h123456});
         wait_clk(T_ER);
      end
      cmd(8'h06, 32'h0, 0);
      cmd(8'h20, 32'h223456, 3);
      wait_clk(10);
      chk_reg(starts[7:0], 8'h04);
      $display("test lock scheme done");
      cmd(8'h01, 32'h80, 1);
      wait_clk(T_WR);
      wp_n <= 1'b0;
      cmd(8'h06, 32'h0, 0);
      cmd(8'h01, 32'h84, 1);
      rd_st(8'h05, 8'h82);
      wp_n <= 1'b1;
      cmd(8'h01, 32'h84, 1);
      wait_clk(T_WR);
      rd_st(8'h05, 8'h84);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h01, 32'h0411, 2);
      wait_clk(T_WR);
      rst_pin_n <= 1'b0;
      wait_clk(20);
      rst_pin_n <= 1'b1;
      wait_clk(10);
      rd_st(8'h05, 8'h04);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h01, 32'h00, 1);
      rd_st(8'h05, 8'h06);
      rst_n <= 1'b0;
      wait_clk(2);
      rst_n <= 1'b1;
      wait_clk(8);
      rd_st(8'h35, 8'h00);
      rd_st(8'h05, 8'h00);
      $display("test lock modes done");
      cmd(8'h06, 32'h0, 0);
      cmd(8'h01, 32'h8001, 2);
      wait_clk(T_WR);
      cmd(8'h06, 32'h0, 0);
      cmd(8'h01, 32'h00, 1);
      rd_st(8'h05, 8'h82);
      cmd(8'h66, 32'h0, 0);
      cmd(8'h99, 32'h0, 0);
      rd_st(8'h05, 8'h80);
      cmd(8'hB9, 32'h0, 0);
      cmd(8'h06, 32'h0, 0);
      cmd(8'hAB, 32'h0, 0);
      rd_st(8'h05, 8'h80);
      cmd(8'h06, 32'h0, 0);
      cmd(8'hC7, 32'h0, 0);
      wait_clk(10);
      chk_mod(last_mod, {2'h3, 24'h000000});
      $display("test resets and power-down done");
      close_out();
   end
endmodule
`default_nettype wire
